//--- common/i2c_slave_pkg.sv
// shared constants and types of the two-wire slave port with bus event detect
package i2c_slave_pkg;

  // ---------------------------------------------------------------
  // register offsets on the plain register port
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_BUF = 8'h13;
  localparam logic [ADDR_W-1:0] OFS_CTL = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DIR = 8'h87;
  localparam logic [ADDR_W-1:0] OFS_IE = 8'h8c;
  localparam logic [ADDR_W-1:0] OFS_OWN = 8'h93;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h94;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int FLAG_PORT_IRQ = 3;
  localparam int IE_PORT_IRQ = 3;
  localparam int DIR_SCL = 3;
  localparam int DIR_SDA = 4;
  localparam logic [DATA_W-1:0] RST_DIR = 8'hff;
  localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;
  localparam logic [2:0] SYNC_IDLE = 3'h7;

  // ---------------------------------------------------------------
  // mode codes and bus constants
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_SLV7 = 4'h6;
  localparam logic [3:0] MODE_SLV10 = 4'h7;
  localparam logic [3:0] MODE_FW_IDLE = 4'hb;
  localparam logic [3:0] MODE_SLV7_SS = 4'he;
  localparam logic [3:0] MODE_SLV10_SS = 4'hf;
  localparam logic [4:0] TEN_BIT_HDR = 5'h1e;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h9;
  localparam logic [3:0] BIT_ONE = 4'h1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_MON
  } phase_t;

  // control register, msb first as it reads back
  typedef struct packed {
    logic writeCollision;
    logic receiveOverflow;
    logic portEnable;
    logic clockRelease;
    logic [3:0] modeSelect;
  } ctl_t;

  // status register, msb first as it reads back
  typedef struct packed {
    logic [1:0] spare;
    logic dataNotAddr;
    logic stopSeen;
    logic startSeen;
    logic readWrite;
    logic updateAddress;
    logic bufferFull;
  } stat_t;

  typedef struct packed {
    logic [2:0] sclSync;
    logic [2:0] sdaSync;
    logic sclLvl;
    logic sdaLvl;
    phase_t phase;
    logic [3:0] bitCnt;
    logic [DATA_W-1:0] shiftRegister;
    logic [DATA_W-1:0] buffer;
    logic [DATA_W-1:0] ownAddr;
    logic [DATA_W-1:0] portDir;
    ctl_t ctl;
    stat_t stat;
    logic irqFlag;
    logic irqEnable;
    logic firstByte;
    logic ackDrive;
    logic ackLatch;
    logic uaHold;
    logic txWait;
    logic hiMatched;
    logic tenDone;
    logic [DATA_W-1:0] rdData;
    logic sclOeN;
    logic sdaOeN;
    logic pinLevel;
    logic intReq;
  } core_t;

endpackage

//--- logic/i2c_slave_event_detect.sv
// two-wire slave port with start/stop detect behind a plain register port

module i2c_slave_event_detect
  import i2c_slave_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [DATA_W-1:0] regRdData,
  input wire logic busClockIn,
  output logic busClockOut,
  output logic busClockOe_n,
  input wire logic busDataIn,
  output logic busDataOut,
  output logic busDataOe_n,
  output logic portIrq
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // a change counts once the second and third stages agree
  function automatic logic lvlNext(input logic [2:0] sync, input logic lvl);
    return (sync[1] == sync[2]) ? sync[2] : lvl;
  endfunction

  function automatic logic [DATA_W-1:0] bitAt(input logic v, input int pos);
    logic [DATA_W-1:0] r;
    r = '0;
    r[pos] = v;
    return r;
  endfunction

  core_t s_reg;
  core_t s_next;
  logic sclLvlNew;
  logic sdaLvlNew;
  logic sclRise;
  logic sclFall;
  logic startEv;
  logic stopEv;
  logic en;
  logic slaveOn;
  logic tenBit;
  logic ssIrq;
  logic wrBuf;
  logic rdBuf;
  logic wrOwn;
  logic hiHdr;

  // ---------------------------------------------------------------
  // pin edges, bus events and decode
  // ---------------------------------------------------------------
  assign sclLvlNew = lvlNext(s_reg.sclSync, s_reg.sclLvl);
  assign sdaLvlNew = lvlNext(s_reg.sdaSync, s_reg.sdaLvl);
  assign sclRise = !s_reg.sclLvl && sclLvlNew;
  assign sclFall = s_reg.sclLvl && !sclLvlNew;
  // data moving while the clock stays high marks start or stop
  assign startEv = s_reg.sclLvl && sclLvlNew && s_reg.sdaLvl && !sdaLvlNew;
  assign stopEv = s_reg.sclLvl && sclLvlNew && !s_reg.sdaLvl && sdaLvlNew;
  assign en = s_reg.ctl.portEnable;
  assign slaveOn = s_reg.ctl.modeSelect inside
    {MODE_SLV7, MODE_SLV10, MODE_SLV7_SS, MODE_SLV10_SS};
  assign tenBit = s_reg.ctl.modeSelect inside {MODE_SLV10, MODE_SLV10_SS};
  assign ssIrq = s_reg.ctl.modeSelect inside
    {MODE_FW_IDLE, MODE_SLV7_SS, MODE_SLV10_SS};
  assign wrBuf = regWrEn && regAddr == OFS_BUF;
  assign rdBuf = regRdEn && regAddr == OFS_BUF;
  assign wrOwn = regWrEn && regAddr == OFS_OWN;
  assign hiHdr = s_reg.shiftRegister[7:3] == TEN_BIT_HDR &&
    s_reg.shiftRegister[2:1] == s_reg.ownAddr[2:1];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic setFlag;
    logic matched;
    logic needUa;
    logic isAddr;
    setFlag = 1'b0;
    matched = 1'b0;
    needUa = 1'b0;
    isAddr = 1'b0;
    s_next = s_reg;
    s_next.sclSync = {s_reg.sclSync[1:0], busClockIn};
    s_next.sdaSync = {s_reg.sdaSync[1:0], busDataIn};
    s_next.sclLvl = sclLvlNew;
    s_next.sdaLvl = sdaLvlNew;
    s_next.rdData = RST_ZERO;

    // register reads
    if (regRdEn) begin
      unique case (regAddr)
        OFS_FLAG: s_next.rdData = bitAt(s_reg.irqFlag, FLAG_PORT_IRQ);
        OFS_IE: s_next.rdData = bitAt(s_reg.irqEnable, IE_PORT_IRQ);
        OFS_BUF: s_next.rdData = s_reg.buffer;
        OFS_CTL: s_next.rdData = s_reg.ctl;
        OFS_DIR: s_next.rdData = s_reg.portDir;
        OFS_OWN: s_next.rdData = s_reg.ownAddr;
        OFS_STAT: s_next.rdData = s_reg.stat;
        default: s_next.rdData = RST_ZERO;
      endcase
    end
    if (rdBuf) begin
      s_next.stat.bufferFull = 1'b0;
    end

    // register writes; hardware sets below win over these clears
    if (regWrEn) begin
      unique case (regAddr)
        OFS_FLAG: s_next.irqFlag = regWrData[FLAG_PORT_IRQ];
        OFS_IE: s_next.irqEnable = regWrData[IE_PORT_IRQ];
        OFS_CTL: s_next.ctl = ctl_t'(regWrData);
        OFS_DIR: s_next.portDir = regWrData;
        OFS_OWN: begin
          s_next.ownAddr = regWrData;
          s_next.stat.updateAddress = 1'b0;
          s_next.uaHold = 1'b0;
        end
        OFS_BUF: begin
          // a byte already on its way out must not be overwritten
          if (s_reg.phase == ST_TX && !s_reg.txWait) begin
            s_next.ctl.writeCollision = 1'b1;
          end else begin
            s_next.buffer = regWrData;
            s_next.shiftRegister = regWrData;
          end
        end
        default: ;
      endcase
    end
    if (s_reg.txWait && s_reg.ctl.clockRelease) begin
      s_next.txWait = 1'b0;
    end

    // bus engine
    if (!en) begin
      s_next.phase = ST_IDLE;
      s_next.stat.startSeen = 1'b0;
      s_next.stat.stopSeen = 1'b0;
      s_next.ackDrive = 1'b0;
      s_next.uaHold = 1'b0;
      s_next.txWait = 1'b0;
      s_next.hiMatched = 1'b0;
      s_next.tenDone = 1'b0;
    end else if (startEv) begin
      s_next.stat.startSeen = 1'b1;
      s_next.stat.stopSeen = 1'b0;
      s_next.bitCnt = '0;
      s_next.ackDrive = 1'b0;
      s_next.txWait = 1'b0;
      s_next.firstByte = 1'b1;
      // mode 1011 only watches the bus
      s_next.phase = slaveOn ? ST_RX : ST_MON;
      setFlag = ssIrq;
    end else if (stopEv) begin
      s_next.stat.stopSeen = 1'b1;
      s_next.stat.startSeen = 1'b0;
      s_next.phase = ST_IDLE;
      s_next.ackDrive = 1'b0;
      s_next.txWait = 1'b0;
      s_next.hiMatched = 1'b0;
      s_next.tenDone = 1'b0;
      setFlag = ssIrq;
    end else begin
      unique case (s_reg.phase)
        ST_IDLE: ;
        ST_MON: begin
          if (sclRise) begin
            s_next.bitCnt = s_reg.bitCnt + BIT_ONE;
          end else if (sclFall && s_reg.bitCnt == ACK_BIT) begin
            s_next.bitCnt = '0;
            setFlag = 1'b1;
          end
        end
        ST_RX: begin
          if (sclRise && s_reg.bitCnt != BYTE_BITS) begin
            s_next.shiftRegister = {s_reg.shiftRegister[6:0], s_reg.sdaLvl};
            s_next.bitCnt = s_reg.bitCnt + BIT_ONE;
          end else if (sclFall && s_reg.bitCnt == BYTE_BITS) begin
            if (s_reg.firstByte) begin
              isAddr = 1'b1;
              if (!tenBit) begin
                matched = s_reg.shiftRegister[7:1] == s_reg.ownAddr[7:1];
              end else if (hiHdr && !s_reg.shiftRegister[0]) begin
                matched = 1'b1;
                needUa = 1'b1;
                s_next.hiMatched = 1'b1;
                s_next.tenDone = 1'b0;
              end else if (hiHdr && s_reg.tenDone) begin
                matched = 1'b1;
              end
            end else if (s_reg.hiMatched && !s_reg.tenDone) begin
              isAddr = 1'b1;
              matched = s_reg.shiftRegister == s_reg.ownAddr;
              needUa = 1'b1;
              s_next.tenDone = matched;
            end else begin
              matched = 1'b1;
            end
            if (matched) begin
              s_next.phase = ST_ACK;
              s_next.firstByte = 1'b0;
              s_next.stat.dataNotAddr = !isAddr;
              if (isAddr) begin
                s_next.stat.readWrite = s_reg.shiftRegister[0];
              end
              if (!s_reg.stat.bufferFull && !s_reg.ctl.receiveOverflow) begin
                s_next.buffer = s_reg.shiftRegister;
                s_next.stat.bufferFull = 1'b1;
                s_next.ackDrive = 1'b1;
                s_next.stat.updateAddress = needUa;
              end else if (s_reg.stat.bufferFull) begin
                s_next.ctl.receiveOverflow = 1'b1;
              end
            end else begin
              s_next.phase = ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            setFlag = 1'b1;
            s_next.ackDrive = 1'b0;
            s_next.bitCnt = '0;
            // an own address write in this same cycle has already let go
            s_next.uaHold = s_next.stat.updateAddress;
            if (s_reg.stat.readWrite && !s_reg.ackDrive) begin
              s_next.phase = ST_IDLE;
            end else if (s_reg.stat.readWrite) begin
              s_next.phase = ST_TX;
              s_next.txWait = 1'b1;
              s_next.ctl.clockRelease = 1'b0;
            end else begin
              s_next.phase = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (!s_reg.txWait && sclFall) begin
            s_next.shiftRegister = {s_reg.shiftRegister[6:0], 1'b0};
            s_next.bitCnt = s_reg.bitCnt + BIT_ONE;
            if (s_reg.bitCnt == LAST_TX_BIT) begin
              s_next.phase = ST_TXACK;
            end
          end
        end
        ST_TXACK: begin
          if (sclRise) begin
            s_next.ackLatch = s_reg.sdaLvl;
            if (s_reg.sdaLvl) begin
              s_next.phase = ST_IDLE;
              s_next.stat.dataNotAddr = 1'b0;
              s_next.stat.readWrite = 1'b0;
              s_next.stat.updateAddress = 1'b0;
              s_next.stat.bufferFull = 1'b0;
              setFlag = 1'b1;
            end
          end else if (sclFall) begin
            setFlag = 1'b1;
            s_next.phase = ST_TX;
            s_next.bitCnt = '0;
            s_next.txWait = 1'b1;
            s_next.ctl.clockRelease = 1'b0;
          end
        end
      endcase
    end
    if (setFlag) begin
      s_next.irqFlag = 1'b1;
    end

    // open-drain pins: enable low means the pin is pulled low
    // a firmware master drives through the direction bits
    s_next.sdaOeN = !(en && (s_next.ackDrive ||
      (s_next.phase == ST_TX && !s_next.shiftRegister[7]) ||
      !s_next.portDir[DIR_SDA]));
    s_next.sclOeN = !(en && (s_next.uaHold ||
      (s_next.txWait && !s_next.ctl.clockRelease) ||
      !s_next.portDir[DIR_SCL]));
    s_next.pinLevel = 1'b0;
    s_next.intReq = s_next.irqFlag && s_next.irqEnable;

    if (rst) begin
      s_next = '0;
      s_next.sclSync = SYNC_IDLE;
      s_next.sdaSync = SYNC_IDLE;
      s_next.sclLvl = 1'b1;
      s_next.sdaLvl = 1'b1;
      s_next.phase = ST_IDLE;
      s_next.portDir = RST_DIR;
      s_next.sclOeN = 1'b1;
      s_next.sdaOeN = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    s_reg <= s_next;
  end

  assign regRdData = s_reg.rdData;
  assign busClockOut = s_reg.pinLevel;
  assign busDataOut = s_reg.pinLevel;
  assign busClockOe_n = s_reg.sclOeN;
  assign busDataOe_n = s_reg.sdaOeN;
  assign portIrq = s_reg.intReq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_byte_end;
    en && s_reg.phase == ST_RX && sclFall && s_reg.bitCnt == BYTE_BITS;
  endsequence

  sequence s_nack_seen;
    en && s_reg.phase == ST_TXACK && sclRise && s_reg.sdaLvl &&
      !startEv && !stopEv;
  endsequence

  property p_flag_ninth;
    en && s_reg.phase == ST_ACK && sclFall |=> s_reg.irqFlag;
  endproperty
  a_flag_ninth: assert property (p_flag_ninth)
    else $error("flag not set at ninth clock fall");

  property p_full_no_ack;
    s_byte_end and (s_reg.stat.bufferFull || s_reg.ctl.receiveOverflow) &&
      !wrBuf |=> !s_reg.ackDrive && $stable(s_reg.buffer);
  endproperty
  a_full_no_ack: assert property (p_full_no_ack)
    else $error("byte taken or acked while buffer full or overflow");

  property p_read_clears_full;
    rdBuf && s_reg.phase inside {ST_IDLE, ST_MON, ST_TX} |=>
      !s_reg.stat.bufferFull;
  endproperty
  a_read_clears_full: assert property (p_read_clears_full)
    else $error("buffer read did not clear full");

  property p_write_loads_shift;
    wrBuf && (s_reg.phase inside {ST_IDLE, ST_ACK} || s_reg.txWait) |=>
      s_reg.shiftRegister == $past(regWrData) &&
      s_reg.buffer == $past(regWrData);
  endproperty
  a_write_loads_shift: assert property (p_write_loads_shift)
    else $error("buffer write did not load shift register");

  property p_ua_stretch;
    s_reg.uaHold |-> !busClockOe_n && s_reg.stat.updateAddress;
  endproperty
  a_ua_stretch: assert property (p_ua_stretch)
    else $error("clock not held while address update pending");

  property p_own_write_release;
    wrOwn && !sclFall |=> !s_reg.stat.updateAddress && !s_reg.uaHold;
  endproperty
  a_own_write_release: assert property (p_own_write_release)
    else $error("own address write did not release clock");

  property p_tx_hold;
    s_reg.txWait && !s_reg.ctl.clockRelease |-> !busClockOe_n;
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("clock not held while waiting for transmit data");

  property p_stop_flag;
    stopEv && en && ssIrq |=> s_reg.irqFlag && s_reg.stat.stopSeen;
  endproperty
  a_stop_flag: assert property (p_stop_flag)
    else $error("stop did not raise the flag");

  property p_disable_clears;
    !en |=> !s_reg.stat.startSeen && !s_reg.stat.stopSeen;
  endproperty
  a_disable_clears: assert property (p_disable_clears)
    else $error("start or stop bit kept while disabled");

  property p_start_seen;
    startEv && en |=> s_reg.stat.startSeen && !s_reg.stat.stopSeen;
  endproperty
  a_start_seen: assert property (p_start_seen)
    else $error("start condition not recorded");

  property p_nack_ends;
    s_nack_seen |=> s_reg.phase == ST_IDLE && !s_reg.stat.bufferFull &&
      s_reg.ackLatch;
  endproperty
  a_nack_ends: assert property (p_nack_ends)
    else $error("transfer not ended after master nack");

endmodule

//--- verification/i2c_master_model.sv
// behavioural two-wire bus master that waits out clock stretching
module i2c_master_model (
  input wire logic sclWire,
  input wire logic sdaWire,
  output logic sclPull,
  output logic sdaPull,
  output logic hung
);
  timeunit 1ns;
  timeprecision 1ns;
  // both lines start released, so the pull-ups hold the bus idle
  initial begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
    hung = 1'b0;
  end
  // ----------------------------------------------------------------
  // line primitives
  // ----------------------------------------------------------------
  // each clock phase lasts 400 ns so the slave's synchroniser and its
  // answer settle well inside the low phase
  task automatic rise();
    int n;
    n = 0;
    sclPull = 1'b0;
    while (sclWire !== 1'b1 && n < 2000) begin
      #50;
      n++;
    end
    if (n >= 2000) hung = 1'b1;
    #400;
  endtask
  task automatic bit_io(input logic b, output logic s);
    #100;
    sdaPull = !b;
    #300;
    rise();
    s = sdaWire;
    sclPull = 1'b1;
  endtask
  // start when toLow is set, stop otherwise
  task automatic cond(input logic toLow);
    #100;
    sdaPull = !toLow;
    #300;
    rise();
    sdaPull = toLow;
    #400;
    sclPull = toLow;
  endtask
  task automatic xfer(input logic [7:0] dOut, input logic ackOut,
                      output logic [7:0] dIn, output logic ackIn);
    for (int i = 7; i >= 0; i--) begin
      bit_io(dOut[i], dIn[i]);
    end
    bit_io(ackOut, ackIn);
  endtask
endmodule

//--- verification/i2c_slave_event_detect_tb.sv
// self-checking bench for the two-wire slave port with event detect
module i2c_slave_event_detect_tb import i2c_slave_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk;
  logic rst;
  logic regWrEn;
  logic regRdEn;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic [7:0] regRdData, got, dummy;
  logic ack, hung, sclPull, sdaPull, portIrq;
  logic busClockOut, busClockOe_n, busDataOut, busDataOe_n;
  logic [15:0] rstTab [7] = '{16'h0c00, 16'h1400, 16'h87ff, 16'h8c00,
                              16'h9300, 16'h9400, 16'h5500};
  // open-drain wires with pull-ups: low whenever any party pulls
  wire sclWire = (busClockOe_n | busClockOut) & !sclPull;
  wire sdaWire = (busDataOe_n | busDataOut) & !sdaPull;
  int failCount = 0;
  int numChecks = 0;
  i2c_slave_event_detect dut (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .busClockIn(sclWire),
    .busClockOut(busClockOut), .busClockOe_n(busClockOe_n),
    .busDataIn(sdaWire), .busDataOut(busDataOut),
    .busDataOe_n(busDataOe_n), .portIrq(portIrq)
  );
  i2c_master_model bm (
    .sclWire(sclWire), .sdaWire(sdaWire), .sclPull(sclPull),
    .sdaPull(sdaPull), .hung(hung)
  );
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = !core_clk;
  end
  // ----------------------------------------------------------------
  // register port and bus helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    numChecks++;
    if (g !== e) begin
      failCount++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hff);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1;
    chk(regRdData & m, e);
  endtask
  task automatic chk_irq(input logic e);
    @(negedge core_clk);
    chk({7'h00, portIrq}, {7'h00, e});
  endtask
  task automatic send(input logic [7:0] d, input logic ea);
    bm.xfer(d, 1'b1, dummy, ack);
    // the ninth fall reaches the slave only after its synchroniser
    repeat (6) @(posedge core_clk);
    chk({7'h00, ack}, {7'h00, ea});
  endtask
  // the slave stretches the clock until software loads and releases
  task automatic serve(input logic [7:0] d, input logic ma,
                       input logic [7:0] c);
    fork
      bm.xfer(8'hff, ma, got, ack);
      begin
        repeat (40) @(negedge core_clk);
        chk({7'h00, busClockOe_n}, 8'h00);
        wr(OFS_BUF, d);
        wr(OFS_CTL, c | 8'h10);
      end
    join
    repeat (6) @(posedge core_clk);
    chk(got, d);
  endtask
  task automatic relay(input logic [7:0] b, input logic [7:0] o);
    repeat (40) @(negedge core_clk);
    chk({7'h00, busClockOe_n}, 8'h00);
    rd(OFS_BUF, b);
    wr(OFS_OWN, o);
  endtask
  task automatic print_verdict();
    if (hung !== 1'b0) begin
      failCount++;
      $display("wrong value at %0t: bus clock held low too long", $time);
    end
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    rst <= 1'b1;
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
    regAddr <= 8'h00;
    regWrData <= 8'h00;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rstTab[i]) rd(rstTab[i][15:8], rstTab[i][7:0]);
    wr(OFS_OWN, 8'ha0);
    wr(OFS_IE, 8'h08);
    bm.cond(1'b1);
    send(8'ha0, 1'b1);
    bm.cond(1'b0);
    rd(OFS_FLAG, 8'h00);
    wr(OFS_CTL, 8'h2e);
    bm.cond(1'b1);
    rd(OFS_STAT, 8'h08);
    rd(OFS_FLAG, 8'h08);
    chk_irq(1'b1);
    send(8'ha2, 1'b1);
    bm.cond(1'b1);
    wr(OFS_FLAG, 8'h00);
    send(8'ha0, 1'b0);
    rd(OFS_STAT, 8'h09);
    rd(OFS_BUF, 8'ha0);
    rd(OFS_STAT, 8'h08);
    rd(OFS_FLAG, 8'h08);
    send(8'h5a, 1'b0);
    rd(OFS_STAT, 8'h29);
    send(8'h33, 1'b1);
    rd(OFS_CTL, 8'h6e);
    rd(OFS_BUF, 8'h5a);
    wr(OFS_FLAG, 8'h00);
    send(8'h44, 1'b1);
    rd(OFS_BUF, 8'h5a);
    rd(OFS_FLAG, 8'h08);
    wr(OFS_CTL, 8'h2e);
    wr(OFS_FLAG, 8'h00);
    bm.cond(1'b0);
    rd(OFS_STAT, 8'h10, 8'h18);
    rd(OFS_FLAG, 8'h08);
    bm.cond(1'b1);
    send(8'ha1, 1'b0);
    rd(OFS_STAT, 8'h0d);
    rd(OFS_BUF, 8'ha1);
    wr(OFS_FLAG, 8'h00);
    serve(8'h96, 1'b0, 8'h2e);
    rd(OFS_FLAG, 8'h08);
    serve(8'h3c, 1'b1, 8'h2e);
    rd(OFS_STAT, 8'h00, 8'he7);
    bm.cond(1'b0);
    wr(OFS_CTL, 8'h2f);
    wr(OFS_OWN, 8'hf6);
    bm.cond(1'b1);
    send(8'hf6, 1'b0);
    rd(OFS_STAT, 8'h03, 8'h07);
    fork
      send(8'h34, 1'b0);
      relay(8'hf6, 8'h34);
    join
    rd(OFS_STAT, 8'h03, 8'h07);
    fork
      bm.cond(1'b1);
      relay(8'h34, 8'hf6);
    join
    send(8'hf7, 1'b0);
    rd(OFS_STAT, 8'h05, 8'h07);
    serve(8'h81, 1'b1, 8'h2f);
    bm.cond(1'b0);
    wr(OFS_CTL, 8'h2b);
    wr(OFS_OWN, 8'ha0);
    wr(OFS_IE, 8'h00);
    bm.cond(1'b1);
    send(8'ha0, 1'b1);
    rd(OFS_FLAG, 8'h08);
    wr(OFS_FLAG, 8'h00);
    wr(OFS_IE, 8'h08);
    chk_irq(1'b0);
    bm.cond(1'b0);
    chk_irq(1'b1);
    // firmware master pulls both lines through the direction bits
    wr(OFS_DIR, 8'he7);
    @(negedge core_clk);
    chk({4'h0, busClockOut, busDataOut, busClockOe_n, busDataOe_n},
        8'h00);
    // writing the reset direction value back lets both lines go again
    wr(OFS_DIR, RST_DIR);
    @(negedge core_clk);
    chk({4'h0, busClockOut, busDataOut, busClockOe_n, busDataOe_n},
        8'h03);
    print_verdict();
  end
endmodule
